// File: core/kdc_defines.svh
// Command codes, field positions, reset values and timing counts
`ifndef KDC_DEFINES_SVH
`define KDC_DEFINES_SVH
`define KDC_OP_MODE 3'h0
`define KDC_OP_CLOCK 3'h1
`define KDC_OP_RD_SENS 3'h2
`define KDC_OP_RD_DISP 3'h3
`define KDC_OP_WR_DISP 3'h4
`define KDC_OP_MSB 7
`define KDC_OP_LSB 5
`define KDC_AI_BIT 4
`define KDC_DM_MSB 4
`define KDC_DM_LSB 3
`define KDC_KM_MSB 2
`define KDC_KM_LSB 0
`define KDC_RST_DISP 2'h1
`define KDC_RST_KBD 3'h0
`define KDC_RST_DIV 5'h1F
`define KDC_MIN_DIV 5'h02
`define KDC_FIFO_DEPTH 4'h8
`define KDC_ST_SENSE 6
`define KDC_ST_OVER 5
`define KDC_ST_UNDER 4
`define KDC_ST_FULL 3
`define KDC_INT_RATE_KHZ 100
`define KDC_KEY_SCAN_US 5100
`define KDC_DEBOUNCE_US 10300
`define KDC_KEY_ROWS 8
`define KDC_ROW_TICKS ((`KDC_KEY_SCAN_US * `KDC_INT_RATE_KHZ) / (1000 * `KDC_KEY_ROWS))
`define KDC_DEB_ROWS ((`KDC_DEBOUNCE_US * `KDC_INT_RATE_KHZ) / (1000 * `KDC_ROW_TICKS))
`endif

// File: core/kdc_pkg.sv
// Types shared by the keyboard/display scan controller
package kdc_pkg;
  typedef struct packed {
    logic cs_n;
    logic buffer_address_select;
    logic rd_n;
    logic wr_n;
    logic [7:0] data;
  } kdc_host_bus_t;

  typedef enum logic [2:0] {
    KEY_IDLE = 3'b001,
    KEY_BOUNCE = 3'b010,
    KEY_HELD = 3'b100
  } kdc_key_st_t;

  typedef struct packed {
    logic wr_n_p;
    logic rd_n_p;
    logic stb_p;
    logic [1:0] display_mode_field;
    logic [2:0] keyboard_mode_field;
    logic [4:0] div;
    logic [4:0] pre_cnt;
    logic [5:0] row_tick;
    logic [3:0] scan;
    logic blank;
    kdc_key_st_t key_st;
    logic [4:0] deb_cnt;
    logic [2:0] key_row;
    logic [2:0] key_col;
    logic [7:0][7:0] fifo;
    logic [2:0] wp;
    logic [2:0] rp;
    logic [3:0] cnt;
    logic err_over;
    logic err_under;
    logic sense_chg;
    logic [2:0] srow;
    logic ai_sens;
    logic rd_disp;
    logic [3:0] daddr;
    logic ai_disp;
    logic [15:0][7:0] dram;
    logic [1:0][7:0] buf_data;
    logic [1:0] buf_n;
    logic [7:0] dout;
    logic irq;
  } kdc_state_t;
endpackage

// File: core/kdc_top.sv
// Keyboard/display scan controller with host command port
`timescale 1ns/10ps
`include "kdc_defines.svh"
module kdc_top #(
  parameter int ROW_TICKS = `KDC_ROW_TICKS,
  parameter int DEB_ROWS = `KDC_DEB_ROWS
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire kdc_pkg::kdc_host_bus_t host_bus_i,
  output logic [7:0] host_data_bus_o,
  output logic host_data_bus_oe_o,
  output logic irq_o,
  output logic [3:0] scan_lines_o,
  input wire logic [7:0] return_lines_i,
  input wire logic shift_i,
  input wire logic control_strobe_input_i,
  output logic [3:0] display_nibble_a_o,
  output logic [3:0] display_nibble_b_o,
  output logic display_blank_out_o
);
  import kdc_pkg::*;

  kdc_state_t q;
  kdc_state_t d;

  function automatic logic [2:0] low_zero(input logic [7:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (!v[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  logic sel;
  logic wr_rise;
  logic rd_fall;
  logic rd_rise;
  logic decoded;
  logic sensor;
  logic strobed;
  logic keyb;
  logic [4:0] div_eff;
  logic tick;
  logic row_end;
  logic [3:0] last;
  logic [2:0] krow;
  logic pop;
  logic push;
  logic [7:0] push_data;
  logic [7:0] cmd;
  logic inc;
  logic dec;

  always_comb begin
    d = q;
    cmd = host_bus_i.data;
    sel = !host_bus_i.cs_n;
    wr_rise = sel && !q.wr_n_p && host_bus_i.wr_n;
    rd_fall = sel && q.rd_n_p && !host_bus_i.rd_n;
    rd_rise = sel && !q.rd_n_p && host_bus_i.rd_n;
    d.wr_n_p = host_bus_i.wr_n;
    d.rd_n_p = host_bus_i.rd_n;
    d.stb_p = control_strobe_input_i;
    decoded = q.keyboard_mode_field[0];
    sensor = q.keyboard_mode_field[2:1] == 2'h2;
    strobed = q.keyboard_mode_field[2:1] == 2'h3;
    keyb = !q.keyboard_mode_field[2];
    inc = 1'b0;
    dec = 1'b0;
    push = 1'b0;
    push_data = 8'h00;
    pop = 1'b0;

    // Prescaler and scan timing chain
    div_eff = (q.div < `KDC_MIN_DIV) ? `KDC_MIN_DIV : q.div;
    tick = q.pre_cnt >= div_eff - 5'h01;
    d.pre_cnt = tick ? 5'h00 : q.pre_cnt + 5'h01;
    row_end = tick && (q.row_tick == 6'(ROW_TICKS - 1));
    // Decoded keyboard caps the display at four digits
    last = decoded ? 4'h3 : (q.display_mode_field[0] ? 4'hF : 4'h7);
    krow = decoded ? {1'b0, q.scan[1:0]} : q.scan[2:0];
    if (tick) begin
      d.row_tick = row_end ? 6'h00 : q.row_tick + 6'h01;
      d.blank = row_end;
    end
    if (row_end) begin
      d.scan = (q.scan >= last) ? 4'h0 : q.scan + 4'h1;
    end

    // Host bus: status, data read, data write, commands
    if (rd_fall) begin
      if (host_bus_i.buffer_address_select) begin
        d.dout = {1'b0, q.sense_chg, q.err_over, q.err_under,
                  q.cnt == `KDC_FIFO_DEPTH, q.cnt[2:0]};
      end else if (q.rd_disp) begin
        d.dout = q.dram[q.daddr];
      end else if (sensor) begin
        d.dout = q.fifo[q.srow];
      end else begin
        d.dout = q.fifo[q.rp];
      end
    end
    if (rd_rise && host_bus_i.buffer_address_select) begin
      // Reading status acknowledges the error flags
      d.err_over = 1'b0;
      d.err_under = 1'b0;
    end
    if (rd_rise && !host_bus_i.buffer_address_select) begin
      if (q.rd_disp) begin
        if (q.ai_disp) begin
          d.daddr = q.daddr + 4'h1;
        end
      end else if (sensor) begin
        d.sense_chg = 1'b0;
        if (q.ai_sens) begin
          d.srow = q.srow + 3'h1;
        end
      end else if (q.cnt == 4'h0) begin
        d.err_under = 1'b1;
      end else begin
        pop = 1'b1;
        dec = 1'b1;
        d.rp = q.rp + 3'h1;
      end
    end
    if (wr_rise && host_bus_i.buffer_address_select) begin
      case (cmd[`KDC_OP_MSB:`KDC_OP_LSB])
        `KDC_OP_MODE: begin
          d.display_mode_field = cmd[`KDC_DM_MSB:`KDC_DM_LSB];
          d.keyboard_mode_field = cmd[`KDC_KM_MSB:`KDC_KM_LSB];
        end
        `KDC_OP_CLOCK: begin
          d.div = cmd[4:0];
        end
        `KDC_OP_RD_SENS: begin
          d.rd_disp = 1'b0;
          d.ai_sens = cmd[`KDC_AI_BIT];
          d.srow = cmd[2:0];
        end
        `KDC_OP_RD_DISP: begin
          d.rd_disp = 1'b1;
          d.ai_disp = cmd[`KDC_AI_BIT];
          d.daddr = cmd[3:0];
        end
        `KDC_OP_WR_DISP: begin
          d.ai_disp = cmd[`KDC_AI_BIT];
          d.daddr = cmd[3:0];
        end
        default: begin
        end
      endcase
    end else if (wr_rise) begin
      d.dram[q.daddr] = cmd;
      if (q.ai_disp) begin
        d.daddr = q.daddr + 4'h1;
      end
    end

    // Key debounce; lockout and rollover both queue one key at a time
    if (row_end && keyb) begin
      case (q.key_st)
        KEY_IDLE: begin
          if (~&return_lines_i) begin
            d.key_row = krow;
            d.key_col = low_zero(return_lines_i);
            d.deb_cnt = 5'h00;
            d.key_st = KEY_BOUNCE;
          end
        end
        KEY_BOUNCE: begin
          if (q.deb_cnt != 5'(DEB_ROWS)) begin
            d.deb_cnt = q.deb_cnt + 5'h01;
          end else if (krow == q.key_row) begin
            if (!return_lines_i[q.key_col]) begin
              push = 1'b1;
              push_data = {control_strobe_input_i, shift_i, q.key_row, q.key_col};
              d.key_st = KEY_HELD;
            end else begin
              d.key_st = KEY_IDLE;
            end
          end
        end
        KEY_HELD: begin
          if (krow == q.key_row && return_lines_i[q.key_col]) begin
            d.key_st = KEY_IDLE;
          end
        end
        default: begin
          d.key_st = KEY_IDLE;
        end
      endcase
    end
    if (strobed && control_strobe_input_i && !q.stb_p) begin
      push = 1'b1;
      push_data = return_lines_i;
    end
    if (row_end && sensor) begin
      if (q.fifo[krow] != return_lines_i) begin
        d.sense_chg = 1'b1;
      end
      d.fifo[krow] = return_lines_i;
    end

    // Two-entry buffer; drain stalls during a FIFO pop
    if (q.buf_n != 2'h0 && !pop) begin
      if (q.cnt == `KDC_FIFO_DEPTH) begin
        d.err_over = 1'b1;
      end else begin
        d.fifo[q.wp] = q.buf_data[0];
        d.wp = q.wp + 3'h1;
        inc = 1'b1;
      end
      d.buf_data[0] = q.buf_data[1];
      d.buf_n = q.buf_n - 2'h1;
    end
    if (push) begin
      if (d.buf_n == 2'h2) begin
        d.err_over = 1'b1;
      end else begin
        d.buf_data[d.buf_n[0]] = push_data;
        d.buf_n = d.buf_n + 2'h1;
      end
    end
    d.cnt = q.cnt + {3'h0, inc} - {3'h0, dec};
    if (sensor) begin
      d.irq = d.sense_chg;
    end else begin
      // Dropped for the read strobe, so a remaining entry shows a new edge
      d.irq = (d.cnt != 4'h0) && !(sel && !host_bus_i.rd_n
              && !host_bus_i.buffer_address_select && !q.rd_disp);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.wr_n_p <= 1'b1;
      q.rd_n_p <= 1'b1;
      q.stb_p <= 1'b1;
      q.display_mode_field <= `KDC_RST_DISP;
      q.keyboard_mode_field <= `KDC_RST_KBD;
      q.div <= `KDC_RST_DIV;
      q.key_st <= KEY_IDLE;
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign host_data_bus_o = q.dout;
  assign host_data_bus_oe_o = !host_bus_i.cs_n && !host_bus_i.rd_n;
  assign irq_o = q.irq;
  assign scan_lines_o = q.keyboard_mode_field[0] ? ~(4'h1 << q.scan[1:0]) : q.scan;
  assign display_nibble_a_o = q.dram[q.scan][7:4];
  assign display_nibble_b_o = q.dram[q.scan][3:0];
  assign display_blank_out_o = q.blank;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_fifo_quiet;
    ce_i && !q.keyboard_mode_field[2] && q.cnt != 4'h0 && host_bus_i.rd_n;
  endsequence

  property p_bus_hiz;
    host_bus_i.cs_n |-> !host_data_bus_oe_o;
  endproperty
  a_bus_hiz: assert property (p_bus_hiz) else $error("bus driven while deselected");

  property p_div_load;
    ce_i && wr_rise && host_bus_i.buffer_address_select && cmd[7:5] == 3'h1
      |=> q.div == $past(cmd[4:0]);
  endproperty
  a_div_load: assert property (p_div_load) else $error("divisor not loaded");

  property p_reset_state;
    $rose(rst_n_i) |-> q.div == 5'h1F && q.keyboard_mode_field == 3'h0
      && q.display_mode_field == 2'h1;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad reset mode");

  property p_decoded_low;
    q.keyboard_mode_field[0] |-> $countones(scan_lines_o) == 3 && !scan_lines_o[q.scan[1:0]];
  endproperty
  a_decoded_low: assert property (p_decoded_low) else $error("decoded scan wrong");

  property p_decoded_four;
    q.keyboard_mode_field[0] && ce_i && row_end |=> q.scan < 4'h4;
  endproperty
  a_decoded_four: assert property (p_decoded_four) else $error("too many digits");

  property p_fifo_bound;
    q.cnt <= 4'h8 && q.wp - q.rp == q.cnt[2:0];
  endproperty
  a_fifo_bound: assert property (p_fifo_bound) else $error("fifo count broken");

  property p_underrun;
    ce_i && rd_rise && !host_bus_i.buffer_address_select && !q.rd_disp
      && !sensor && q.cnt == 4'h0 |=> q.err_under;
  endproperty
  a_underrun: assert property (p_underrun) else $error("underrun not flagged");

  property p_irq_held;
    s_fifo_quiet ##1 s_fifo_quiet |-> irq_o;
  endproperty
  a_irq_held: assert property (p_irq_held) else $error("irq low with data");

  property p_strobe_take;
    ce_i && strobed && control_strobe_input_i && !q.stb_p && q.buf_n == 2'h0
      |=> q.buf_n == 2'h1 && q.buf_data[0] == $past(return_lines_i);
  endproperty
  a_strobe_take: assert property (p_strobe_take) else $error("strobe byte lost");

  property p_prescale;
    q.pre_cnt < 5'h1F && (q.pre_cnt < div_eff || q.div != $past(q.div));
  endproperty
  a_prescale: assert property (p_prescale) else $error("prescaler overran");

  // Buffer must be idle, or a late drain could overwrite the copied row
  property p_sensor_copy;
    ce_i && row_end && sensor && q.buf_n == 2'h0
      |=> q.fifo[$past(krow)] == $past(return_lines_i);
  endproperty
  a_sensor_copy: assert property (p_sensor_copy) else $error("sensor row lost");

  property p_disp_write;
    ce_i && wr_rise && !host_bus_i.buffer_address_select
      |=> q.dram[$past(q.daddr)] == $past(cmd);
  endproperty
  a_disp_write: assert property (p_disp_write) else $error("display write lost");

  property p_read_advance;
    ce_i && rd_rise && !host_bus_i.buffer_address_select && q.rd_disp && q.ai_disp
      |=> q.daddr == $past(q.daddr) + 4'h1;
  endproperty
  a_read_advance: assert property (p_read_advance) else $error("no advance");

  property p_blank_step;
    ce_i && row_end |=> display_blank_out_o;
  endproperty
  a_blank_step: assert property (p_blank_step) else $error("blank missing");

  sequence s_key_confirm;
    ce_i && row_end && keyb && q.key_st == KEY_BOUNCE && q.deb_cnt == 5'(DEB_ROWS)
      && krow == q.key_row && !return_lines_i[q.key_col] && q.buf_n == 2'h0;
  endsequence

  property p_key_take;
    s_key_confirm |=> q.buf_n == 2'h1
      && q.buf_data[0] == {$past(control_strobe_input_i), $past(shift_i),
                           $past(q.key_row), $past(q.key_col)};
  endproperty
  a_key_take: assert property (p_key_take) else $error("key entry lost");
endmodule

// File: bench/kdc_host_model.sv
// Bus host model: command, data and status cycles with held strobes
`timescale 1ns/10ps
module kdc_host_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output kdc_pkg::kdc_host_bus_t bus_o
);
  import kdc_pkg::*;
  initial bus_o = '{1'b1, 1'b0, 1'b1, 1'b1, 8'h5A};
  // Strobe low three cycles, leaving margin over the two-cycle minimum
  task automatic access(input logic sel, input logic wr, input logic [7:0] wdata,
                        output logic [7:0] rdata);
    @(negedge clk_i);
    bus_o.cs_n = 1'b0;
    bus_o.buffer_address_select = sel;
    bus_o.data = wr ? wdata : ~bus_o.data;
    bus_o.wr_n = !wr;
    bus_o.rd_n = wr;
    repeat (3) @(posedge clk_i);
    rdata = rdata_i;
    @(negedge clk_i);
    bus_o.wr_n = 1'b1;
    bus_o.rd_n = 1'b1;
    // Select held past the strobe edge so the write is still taken
    @(negedge clk_i);
    bus_o.cs_n = 1'b1;
    // Released lines show the inverse, never a stale byte
    bus_o.data = ~bus_o.data;
    repeat (2) @(negedge clk_i);
  endtask
endmodule

// File: bench/kdc_top_tb.sv
// Self-checking bench for the scan controller
`timescale 1ns/10ps
module kdc_top_tb;
  import kdc_pkg::*;
  localparam int RT = 2;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  kdc_host_bus_t bus;
  logic [7:0] dout, sdat, r, v, junk;
  logic [7:0] rl = 8'hFF;
  logic oe, irq, blank, shift, cstb, key_on, saw;
  logic ce = 1'b1;
  logic [3:0] scan, na, nb, top;
  logic [2:0] kmode, key_r, key_c;
  logic [31:0] seed = 32'h3C13;
  int n_fail = 0;
  int tests_run = 0;
  int divs[3] = '{3, 0, 2};
  logic [7:0] modes[8] = '{8'h08, 8'h00, 8'h18, 8'h10, 8'h09, 8'h1B, 8'h0D, 8'h1F};
  logic [3:0] tops[8] = '{4'hF, 4'h7, 4'hF, 4'h7, 4'h3, 4'h3, 4'h3, 4'h3};
  logic [7:0] exp_q[$];
  logic [7:0] dram[16];
  logic [7:0] sens[8];
  always #4 clk_i = ~clk_i;
  kdc_top #(.ROW_TICKS(RT), .DEB_ROWS(2)) dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .host_bus_i(bus),
    .host_data_bus_o(dout), .host_data_bus_oe_o(oe), .irq_o(irq), .scan_lines_o(scan),
    .return_lines_i(rl), .shift_i(shift), .control_strobe_input_i(cstb),
    .display_nibble_a_o(na), .display_nibble_b_o(nb), .display_blank_out_o(blank));
  kdc_host_model u_host (.clk_i(clk_i), .rdata_i(dout), .bus_o(bus));
  // Pulled-up matrix: a pressed key pulls its column low while its row is scanned
  always @(negedge clk_i) begin
    if (kmode[2:1] == 2'b10) rl <= sens[scan[2:0]];
    else if (kmode[2:1] == 2'b11) rl <= sdat;
    else rl <= (key_on && scan[2:0] == key_r) ? ~(8'h01 << key_c) : 8'hFF;
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [7:0] st_exp(input logic [3:0] n, input logic ov, input logic un);
    return {2'b00, ov, un, n[3], n[2:0]};
  endfunction
  function automatic logic [7:0] key_exp(input logic c, input logic s, input logic [5:0] pos);
    return {c, s, pos};
  endfunction
  function automatic logic [3:0] dec_idx(input logic [3:0] s);
    dec_idx = 4'hF;
    for (int i = 3; i >= 0; i--) if (!s[i]) dec_idx = 4'(i);
  endfunction
  task automatic rnd8(output logic [7:0] o);
    seed = nxt(seed);
    o = seed[7:0];
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic print_verdict();
    if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] b);
    u_host.access(1'b1, 1'b1, b, junk);
  endtask
  task automatic dwr(input logic [7:0] b);
    u_host.access(1'b0, 1'b1, b, junk);
  endtask
  task automatic rd(input logic sel, output logic [7:0] o);
    u_host.access(sel, 1'b0, 8'h00, o);
  endtask
  task automatic row_period(output logic [7:0] n);
    logic [3:0] s;
    n = 8'h00;
    s = scan;
    for (int i = 0; i < 200 && scan === s; i++) @(negedge clk_i);
    s = scan;
    for (int i = 0; i < 200 && scan === s; i++) begin
      @(negedge clk_i);
      n++;
    end
  endtask
  // Settling time first: the count may sit beyond the new wrap point
  task automatic watch(input logic dec);
    logic [3:0] idx;
    top = 4'h0;
    saw = 1'b0;
    repeat (80) @(negedge clk_i);
    for (int i = 0; i < 400; i++) begin
      @(negedge clk_i);
      idx = dec ? dec_idx(scan) : scan;
      if (dec) check({4'h0, scan}, {4'h0, ~(4'h1 << idx[1:0])}, "decoded scan");
      if (!blank) check({na, nb}, dram[idx], "display nibbles");
      if (blank) saw = 1'b1;
      if (idx > top) top = idx;
    end
    check({7'h0, saw}, 8'h01, "blank at digit change");
  endtask
  always @(posedge clk_i) begin
    if (rst_n_i) check({7'h0, oe}, {7'h0, !bus.cs_n && !bus.rd_n}, "bus enable");
  end
  initial begin
    repeat (50000) @(posedge clk_i);
    n_fail++;
    print_verdict();
  end
  initial begin
    shift = 1'b1;
    cstb = 1'b1;
    key_on = 1'b0;
    kmode = 3'h0;
    sdat = 8'hFF;
    key_r = 3'h0;
    key_c = 3'h0;
    foreach (sens[i]) sens[i] = 8'hFF;
    foreach (dram[i]) dram[i] = 8'h00;
    repeat (20) @(negedge clk_i);
    rst_n_i = 1'b1;
    check({7'h0, irq}, 8'h00, "irq after reset");
    rd(1'b1, r);
    check(r, st_exp(4'h0, 1'b0, 1'b0), "status after reset");
    row_period(v);
    check(v, 8'(RT * 31), "reset divisor");
    foreach (divs[i]) begin
      cmd({3'h1, 5'(divs[i])});
      row_period(v);
      check(v, 8'(RT * ((divs[i] < 2) ? 2 : divs[i])), "row period");
    end
    // Enable low must freeze the whole timing chain
    ce = 1'b0;
    top = scan;
    repeat (40) @(negedge clk_i);
    check({4'h0, scan}, {4'h0, top}, "scan frozen");
    ce = 1'b1;
    cmd(8'h06);
    kmode = 3'h6;
    cmd(8'h40);
    for (int i = 0; i < 9; i++) begin
      rnd8(sdat);
      if (i < 8) exp_q.push_back(sdat);
      repeat (2) @(negedge clk_i);
      cstb = 1'b0;
      repeat (3) @(negedge clk_i);
      cstb = 1'b1;
      repeat (4) @(negedge clk_i);
      check({7'h0, irq}, 8'h01, "irq with data");
    end
    rd(1'b1, r);
    check(r, st_exp(4'h8, 1'b1, 1'b0), "status full overrun");
    for (int i = 0; i < 8; i++) begin
      rd(1'b0, r);
      check(r, exp_q.pop_front(), "fifo order");
      check({7'h0, irq}, {7'h0, i < 7}, "irq after pop");
    end
    rd(1'b0, r);
    rd(1'b1, r);
    check(r, st_exp(4'h0, 1'b0, 1'b1), "status underrun");
    cmd(8'h90);
    for (int i = 0; i < 16; i++) begin
      rnd8(dram[i]);
      dwr(dram[i]);
    end
    cmd(8'h70);
    for (int i = 0; i < 16; i++) begin
      rd(1'b0, r);
      check(r, dram[i], "display readback");
    end
    rnd8(v);
    cmd(8'h85);
    dwr(~v);
    dwr(v);
    dram[5] = v;
    cmd(8'h65);
    repeat (2) begin
      rd(1'b0, r);
      check(r, v, "address held");
    end
    cmd(8'h93);
    rd(1'b0, r);
    check(r, dram[3], "read source kept");
    for (int i = 0; i < 2; i++) begin
      cmd(i ? 8'h02 : 8'h00);
      kmode = 3'h0;
      cmd(8'h40);
      rnd8(v);
      {cstb, shift, key_r, key_c} = v;
      key_on = 1'b1;
      repeat (300) @(negedge clk_i);
      key_on = 1'b0;
      repeat (100) @(negedge clk_i);
      check({7'h0, irq}, 8'h01, "key irq");
      rd(1'b0, r);
      check(r, key_exp(v[7], v[6], v[5:0]), "key code");
      cstb = 1'b1;
    end
    foreach (modes[i]) begin
      cmd(modes[i]);
      kmode = modes[i][2:0];
      watch(modes[i][0]);
      check({4'h0, top}, {4'h0, tops[i]}, "scan wrap");
    end
    cmd(8'h04);
    kmode = 3'h4;
    // Earlier modes leave the change flag set; a sensor read clears it first
    repeat (100) @(negedge clk_i);
    rd(1'b0, r);
    check(r, 8'hFF, "sensor idle row");
    repeat (100) @(negedge clk_i);
    check({7'h0, irq}, 8'h00, "sensor quiet irq");
    foreach (sens[i]) rnd8(sens[i]);
    repeat (200) @(negedge clk_i);
    check({7'h0, irq}, 8'h01, "sensor change irq");
    cmd(8'h50);
    for (int i = 0; i < 8; i++) begin
      rd(1'b0, r);
      check(r, sens[i], "sensor row");
    end
    cmd(8'h43);
    rd(1'b0, r);
    check(r, sens[3], "sensor row held");
    print_verdict();
  end
endmodule
